// ---- common/gauge_warn_pkg.sv ----
// constants and types shared by the low-capacity warning block
package gauge_warn_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int CAP_WIDTH = 16;
    localparam int LEVEL_WIDTH = 8;
    localparam int DATA_WIDTH = 32;
    localparam int ADDR_WIDTH = 5;
    localparam int EVT_COUNT = 4;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [ADDR_WIDTH-1:0] OFS_CAPACITY = 5'h00;
    localparam logic [ADDR_WIDTH-1:0] OFS_LEVELS = 5'h04;
    localparam logic [ADDR_WIDTH-1:0] OFS_FLAGS = 5'h08;
    localparam logic [ADDR_WIDTH-1:0] OFS_IRQ_STATUS = 5'h0C;
    localparam logic [ADDR_WIDTH-1:0] OFS_IRQ_MASK = 5'h10;

    // ****************************************
    // field positions
    // ****************************************
    localparam int LVL_INIT_SET_LSB = 0;
    localparam int LVL_INIT_CLEAR_LSB = 8;
    localparam int LVL_FINAL_SET_LSB = 16;
    localparam int LVL_FINAL_CLEAR_LSB = 24;
    localparam int FLAG_INIT_BIT = 0;
    localparam int FLAG_FINAL_BIT = 1;
    localparam int EVT_INIT_SET = 0;
    localparam int EVT_INIT_CLEAR = 1;
    localparam int EVT_FINAL_SET = 2;
    localparam int EVT_FINAL_CLEAR = 3;

    // ****************************************
    // values after reset (levels in mAh)
    // ****************************************
    localparam logic [LEVEL_WIDTH-1:0] RST_INIT_SET = 8'h96;
    localparam logic [LEVEL_WIDTH-1:0] RST_INIT_CLEAR = 8'hAF;
    localparam logic [LEVEL_WIDTH-1:0] RST_FINAL_SET = 8'h4B;
    localparam logic [LEVEL_WIDTH-1:0] RST_FINAL_CLEAR = 8'h64;
    localparam logic [CAP_WIDTH-1:0] RST_CAPACITY = 16'hFFFF;
    localparam logic [EVT_COUNT-1:0] RST_IRQ_MASK = 4'h0;

    // ****************************************
    // bus answer state machine
    // ****************************************
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ANSWER = 2'b10
    } bus_state_type;

endpackage : gauge_warn_pkg

// ---- common/flag_eval_if.sv ----
// carrier between the register side and the hysteresis flag evaluator
`timescale 1ns/100ps
interface flag_eval_if #(
    parameter int CAP_W = 16,
    parameter int LEVEL_W = 8,
    parameter int EVT_W = 4
);
    logic update;
    logic [CAP_W-1:0] capacity;
    logic [LEVEL_W-1:0] init_set;
    logic [LEVEL_W-1:0] init_clear;
    logic [LEVEL_W-1:0] final_set;
    logic [LEVEL_W-1:0] final_clear;
    logic initial_flag;
    logic final_flag;
    logic [EVT_W-1:0] evt;

    modport source (output update, capacity, init_set, init_clear, final_set, final_clear,
        input initial_flag, final_flag, evt);
    modport evaluator (input update, capacity, init_set, init_clear, final_set, final_clear,
        output initial_flag, final_flag, evt);
endinterface : flag_eval_if

// ---- src/hysteresis_flags.sv ----
// two warning flags with set/clear hysteresis against the capacity left
`timescale 1ns/100ps
module hysteresis_flags
    import gauge_warn_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    flag_eval_if.evaluator ev
);
    logic init_ff;
    logic final_ff;
    logic [EVT_COUNT-1:0] evt_ff;
    logic nxt_init;
    logic nxt_final;
    logic init_below;
    logic init_above;
    logic final_armed;
    logic final_below;
    logic final_above;

    // ****************************************
    // comparisons, levels widened to the capacity width
    // ****************************************
    assign init_below = ev.capacity < CAP_WIDTH'(ev.init_set);
    assign init_above = ev.capacity > CAP_WIDTH'(ev.init_clear);
    // zero set level switches the final warning off
    assign final_armed = ev.final_set != '0;
    assign final_below = final_armed && (ev.capacity < CAP_WIDTH'(ev.final_set));
    assign final_above = ev.capacity > CAP_WIDTH'(ev.final_clear);

    // next flag values; set wins if the levels were programmed crossed
    always_comb begin
        nxt_init = init_ff;
        nxt_final = final_ff;
        if (ev.update) begin
            if (init_below) begin
                nxt_init = 1'b1;
            end else if (init_above) begin
                nxt_init = 1'b0;
            end
            if (final_below) begin
                nxt_final = 1'b1;
            end else if (final_ff && final_above) begin
                nxt_final = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            init_ff <= 1'b0;
            final_ff <= 1'b0;
            evt_ff <= '0;
        end else begin
            init_ff <= nxt_init;
            final_ff <= nxt_final;
            evt_ff[EVT_INIT_SET] <= nxt_init && !init_ff;
            evt_ff[EVT_INIT_CLEAR] <= !nxt_init && init_ff;
            evt_ff[EVT_FINAL_SET] <= nxt_final && !final_ff;
            evt_ff[EVT_FINAL_CLEAR] <= !nxt_final && final_ff;
        end
    end

    assign ev.initial_flag = init_ff;
    assign ev.final_flag = final_ff;
    assign ev.evt = evt_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_init_set_low: assert property (
        ev.update && init_below |=> init_ff && (evt_ff[EVT_INIT_SET] == !$past(init_ff)))
        else $error("initial flag not set below its set level");
    chk_init_clear_high: assert property (
        ev.update && init_above && !init_below |=> !init_ff)
        else $error("initial flag not cleared above its clear level");
    chk_init_band_hold: assert property (
        ev.update && !init_above && !init_below |=> $stable(init_ff))
        else $error("initial flag moved inside the hysteresis band");
    chk_final_set_low: assert property (
        ev.update && final_armed && final_below |=> final_ff)
        else $error("final flag not set below its set level");
    chk_final_zero_off: assert property (
        ev.update && !final_armed && !final_ff |=> !final_ff)
        else $error("final flag raised with zero set level");
    chk_final_clear_high: assert property (
        ev.update && final_ff && final_above && !final_below |=> !final_ff)
        else $error("final flag not cleared above its clear level");
    chk_flags_hold_idle: assert property (
        !ev.update |=> $stable(init_ff) && $stable(final_ff))
        else $error("flag changed without a capacity update");
endmodule : hysteresis_flags

// ---- src/low_capacity_warning_flags.sv ----
// low-capacity warning block: charge counter, warn levels, flags, pin, Avalon-MM slave
//
// Behaviour
// - capacity left follows accumulated charge, both charging and discharging
// - initial flag sets when capacity left drops below initial set level
// - initial flag clears only once capacity climbs above initial clear level
// - low battery pin always follows the initial flag, no host action
// - final flag sets when capacity left drops below final set level
// - final set level of zero disables the final warning
// - final flag clears above final clear level, only when already set
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module low_capacity_warning_flags
    import gauge_warn_pkg::*;
#(
    parameter int CAP_W = gauge_warn_pkg::CAP_WIDTH
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [gauge_warn_pkg::ADDR_WIDTH-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [gauge_warn_pkg::DATA_WIDTH-1:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [gauge_warn_pkg::DATA_WIDTH-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic CHARGE_VALID,
    input wire logic [gauge_warn_pkg::CAP_WIDTH-1:0] CHARGE_DELTA,
    output logic LOW_BATTERY_PIN,
    output logic IRQ
);
    import gauge_warn_pkg::*;

    // ****************************************
    // elaboration check
    // ****************************************
    // the counter and the bus window are both sized by the package width
    if (CAP_W != CAP_WIDTH) begin : g_bad_width
        $error("CAP_W must equal the package capacity width");
    end

    // ****************************************
    // declarations
    // ****************************************
    bus_state_type bus_state_ff;
    bus_state_type nxt_bus_state;
    logic waitreq_ff;
    logic [DATA_WIDTH-1:0] rdata_ff;
    logic [DATA_WIDTH-1:0] nxt_rdata;
    logic [CAP_WIDTH-1:0] capacity_ff;
    logic [CAP_WIDTH-1:0] nxt_capacity;
    logic [DATA_WIDTH-1:0] levels_ff;
    logic [EVT_COUNT-1:0] status_ff;
    logic [EVT_COUNT-1:0] nxt_status;
    logic [EVT_COUNT-1:0] mask_ff;
    logic upd_ff;
    logic pin_ff;
    logic irq_ff;
    logic bus_req;
    logic wr_commit;
    logic wr_capacity;
    logic wr_levels;
    logic wr_status;
    logic wr_mask;
    logic signed [CAP_WIDTH+1:0] charge_sum;
    logic sum_low;
    logic sum_high;
    logic [EVT_COUNT-1:0] w1c_bits;

    flag_eval_if #(
        .CAP_W(CAP_WIDTH),
        .LEVEL_W(LEVEL_WIDTH),
        .EVT_W(EVT_COUNT)
    ) ev_if ();

    // ****************************************
    // helper functions
    // ****************************************
    // byte-lane merge of a write into an old word
    function automatic logic [DATA_WIDTH-1:0] merge_bytes(
        input logic [DATA_WIDTH-1:0] old_word,
        input logic [DATA_WIDTH-1:0] new_word,
        input logic [3:0] lanes
    );
        logic [DATA_WIDTH-1:0] result;
        result = old_word;
        for (int i = 0; i < 4; i++) begin
            if (lanes[i]) begin
                result[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return result;
    endfunction : merge_bytes

    // register read decode; unmapped words read as zero
    function automatic logic [DATA_WIDTH-1:0] read_word(
        input logic [ADDR_WIDTH-1:0] addr,
        input logic [CAP_WIDTH-1:0] cap,
        input logic [DATA_WIDTH-1:0] lvl,
        input logic init_flag,
        input logic final_flag,
        input logic [EVT_COUNT-1:0] status,
        input logic [EVT_COUNT-1:0] mask
    );
        logic [DATA_WIDTH-1:0] word;
        word = '0;
        case (addr)
            OFS_CAPACITY: begin
                word[CAP_WIDTH-1:0] = cap;
            end
            OFS_LEVELS: begin
                word = lvl;
            end
            OFS_FLAGS: begin
                word[FLAG_INIT_BIT] = init_flag;
                word[FLAG_FINAL_BIT] = final_flag;
            end
            OFS_IRQ_STATUS: begin
                word[EVT_COUNT-1:0] = status;
            end
            OFS_IRQ_MASK: begin
                word[EVT_COUNT-1:0] = mask;
            end
            default: begin
                word = '0;
            end
        endcase
        return word;
    endfunction : read_word

    // ****************************************
    // Avalon-MM slave
    // ****************************************
    // every access answers in the cycle after it is seen; the fixed wait
    // costs one cycle but keeps read data a clean flip-flop output
    assign bus_req = AVS_READ || AVS_WRITE;
    assign wr_commit = (bus_state_ff == BUS_ANSWER) && AVS_WRITE;
    assign wr_capacity = wr_commit && (AVS_ADDRESS == OFS_CAPACITY);
    assign wr_levels = wr_commit && (AVS_ADDRESS == OFS_LEVELS);
    assign wr_status = wr_commit && (AVS_ADDRESS == OFS_IRQ_STATUS);
    assign wr_mask = wr_commit && (AVS_ADDRESS == OFS_IRQ_MASK);

    // answer state and read data
    always_comb begin
        nxt_bus_state = bus_state_ff;
        nxt_rdata = rdata_ff;
        case (bus_state_ff)
            BUS_IDLE: begin
                if (bus_req) begin
                    nxt_bus_state = BUS_ANSWER;
                    nxt_rdata = read_word(AVS_ADDRESS, capacity_ff, levels_ff,
                        ev_if.initial_flag, ev_if.final_flag, status_ff, mask_ff);
                end
            end
            BUS_ANSWER: begin
                nxt_bus_state = BUS_IDLE;
            end
            default: begin
                nxt_bus_state = BUS_IDLE;
            end
        endcase
    end

    // bus state registers
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            bus_state_ff <= BUS_IDLE;
            waitreq_ff <= 1'b1;
            rdata_ff <= '0;
        end else begin
            bus_state_ff <= nxt_bus_state;
            waitreq_ff <= (nxt_bus_state != BUS_ANSWER);
            rdata_ff <= nxt_rdata;
        end
    end

    // ****************************************
    // capacity counter
    // ****************************************
    // signed charge added to the counter, two guard bits for saturation
    assign charge_sum = $signed({2'b00, capacity_ff})
        + $signed({{2{CHARGE_DELTA[CAP_WIDTH-1]}}, CHARGE_DELTA});
    assign sum_low = charge_sum < 0;
    assign sum_high = charge_sum[CAP_WIDTH];

    // software load wins over a charge sample in the same cycle
    always_comb begin
        nxt_capacity = capacity_ff;
        if (wr_capacity) begin
            nxt_capacity = CAP_WIDTH'(merge_bytes({{(DATA_WIDTH-CAP_WIDTH){1'b0}}, capacity_ff},
                AVS_WRITEDATA, AVS_BYTEENABLE));
        end else if (CHARGE_VALID) begin
            if (sum_low) begin
                nxt_capacity = '0;
            end else if (sum_high) begin
                nxt_capacity = '1;
            end else begin
                nxt_capacity = charge_sum[CAP_WIDTH-1:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            capacity_ff <= RST_CAPACITY;
            upd_ff <= 1'b0;
        end else begin
            capacity_ff <= nxt_capacity;
            upd_ff <= wr_capacity || CHARGE_VALID;
        end
    end

    // ****************************************
    // warn levels
    // ****************************************
    // levels in mAh, one byte each
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            levels_ff <= '0;
            levels_ff[LVL_INIT_SET_LSB +: LEVEL_WIDTH] <= RST_INIT_SET;
            levels_ff[LVL_INIT_CLEAR_LSB +: LEVEL_WIDTH] <= RST_INIT_CLEAR;
            levels_ff[LVL_FINAL_SET_LSB +: LEVEL_WIDTH] <= RST_FINAL_SET;
            levels_ff[LVL_FINAL_CLEAR_LSB +: LEVEL_WIDTH] <= RST_FINAL_CLEAR;
        end else if (wr_levels) begin
            levels_ff <= merge_bytes(levels_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
        end
    end

    // ****************************************
    // flag evaluator
    // ****************************************
    assign ev_if.update = upd_ff;
    assign ev_if.capacity = capacity_ff;
    assign ev_if.init_set = levels_ff[LVL_INIT_SET_LSB +: LEVEL_WIDTH];
    assign ev_if.init_clear = levels_ff[LVL_INIT_CLEAR_LSB +: LEVEL_WIDTH];
    assign ev_if.final_set = levels_ff[LVL_FINAL_SET_LSB +: LEVEL_WIDTH];
    assign ev_if.final_clear = levels_ff[LVL_FINAL_CLEAR_LSB +: LEVEL_WIDTH];

    hysteresis_flags u_flags (
        .clk(CLK),
        .nrst(NRST),
        .ev(ev_if.evaluator)
    );

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            pin_ff <= 1'b0;
        end else begin
            pin_ff <= ev_if.initial_flag;
        end
    end

    // ****************************************
    // interrupt status and mask
    // ****************************************
    // write one to clear, lane 0 only; a new event in the same cycle wins
    assign w1c_bits = (wr_status && AVS_BYTEENABLE[0]) ? AVS_WRITEDATA[EVT_COUNT-1:0] : '0;
    assign nxt_status = (status_ff & ~w1c_bits) | ev_if.evt;

    // sticky status, mask and level interrupt
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            status_ff <= '0;
            mask_ff <= RST_IRQ_MASK;
            irq_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            if (wr_mask && AVS_BYTEENABLE[0]) begin
                mask_ff <= AVS_WRITEDATA[EVT_COUNT-1:0];
            end
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign AVS_READDATA = rdata_ff;
    assign AVS_WAITREQUEST = waitreq_ff;
    assign LOW_BATTERY_PIN = pin_ff;
    assign IRQ = irq_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    chk_charge_accumulate: assert property (
        CHARGE_VALID && !wr_capacity && !sum_low && !sum_high
        |=> capacity_ff == $past(charge_sum[CAP_WIDTH-1:0]))
        else $error("capacity did not take the accumulated charge");
    chk_charge_floor: assert property (
        CHARGE_VALID && !wr_capacity && sum_low |=> capacity_ff == '0)
        else $error("capacity did not saturate at zero");
    chk_pin_follow: assert property (
        ev_if.initial_flag |=> LOW_BATTERY_PIN ##1 LOW_BATTERY_PIN == $past(ev_if.initial_flag))
        else $error("low battery pin does not follow the initial flag");
    chk_update_after_change: assert property (
        capacity_ff != $past(capacity_ff) |-> upd_ff)
        else $error("capacity changed without an update pulse");
    chk_bus_answer_one: assert property (
        bus_req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("bus answer not given in the following cycle");

    cov_initial_warn: cover property (!ev_if.initial_flag ##1 ev_if.initial_flag);
    cov_final_warn: cover property (!ev_if.final_flag ##1 ev_if.final_flag);
    cov_irq_raise: cover property (!IRQ ##1 IRQ);
    cov_write_commit: cover property (wr_levels);
endmodule : low_capacity_warning_flags

// ---- testbench/host_pin_model.sv ----
// host-side observer of the low-battery pin
`timescale 1ns/100ps
module host_pin_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic pin,
    output int alarms
);
    logic last_ff;

    // pin alarm count
    // host firmware only reacts to a fresh rise, so a held pin counts once
    always @(posedge clk) begin
        if (!nrst) begin
            alarms <= 0;
            last_ff <= 1'b0;
        end else begin
            last_ff <= pin;
            if (pin && !last_ff) begin
                alarms <= alarms + 1;
            end
        end
    end
endmodule : host_pin_model

// ---- testbench/testbench.sv ----
// self-checking bench for the low-capacity warning block
`timescale 1ns/100ps
module testbench;
    import gauge_warn_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [ADDR_WIDTH-1:0] adr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [DATA_WIDTH-1:0] wdat = '0;
    logic [3:0] be = 4'hF;
    logic [DATA_WIDTH-1:0] rdat;
    logic wait_req;
    logic chg_vld = 1'b0;
    logic [CAP_WIDTH-1:0] chg = '0;
    logic pin;
    logic irq;
    int alarms;
    int miscompares = 0;
    int samples_checked = 0;
    int seed = 21829;
    int rises = 0;
    logic [DATA_WIDTH-1:0] exp_q[$];
    // reference state, kept apart from the design
    logic [CAP_WIDTH-1:0] cap = RST_CAPACITY;
    logic [LEVEL_WIDTH-1:0] iset = RST_INIT_SET;
    logic [LEVEL_WIDTH-1:0] iclr = RST_INIT_CLEAR;
    logic [LEVEL_WIDTH-1:0] fset = RST_FINAL_SET;
    logic [LEVEL_WIDTH-1:0] fclr = RST_FINAL_CLEAR;
    logic fi = 1'b0;
    logic ff = 1'b0;
    logic [3:0] sts = 4'h0;
    logic [3:0] msk = 4'h0;

    // ****************************************
    // clock, design and partner
    // ****************************************
    always #2 clk = ~clk;

    low_capacity_warning_flags #(.CAP_W(CAP_WIDTH)) low_capacity_warning_flags_i (
        .CLK(clk), .NRST(nrst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wait_req), .CHARGE_VALID(chg_vld), .CHARGE_DELTA(chg),
        .LOW_BATTERY_PIN(pin), .IRQ(irq));

    host_pin_model host_pin_model_i (.clk(clk), .nrst(nrst), .pin(pin), .alarms(alarms));

    // ****************************************
    // compare and close
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // read data is taken only at the edge where waitrequest is seen low
    always @(posedge clk) begin
        if (rd === 1'b1 && wait_req === 1'b0 && exp_q.size() > 0) begin
            check(rdat, exp_q.pop_front());
        end
    end

    // ****************************************
    // bus and charge drivers
    // ****************************************
    task automatic access(input logic is_wr, input logic [ADDR_WIDTH-1:0] a,
            input logic [DATA_WIDTH-1:0] d, input logic [3:0] lanes);
        @(posedge clk);
        adr <= a;
        wr <= is_wr;
        rd <= ~is_wr;
        wdat <= d;
        be <= lanes;
        @(posedge clk);
        while (wait_req !== 1'b0) @(posedge clk);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : access

    task automatic rd_chk(input logic [ADDR_WIDTH-1:0] a, input logic [DATA_WIDTH-1:0] e);
        exp_q.push_back(e);
        access(1'b0, a, '0, 4'hF);
    endtask : rd_chk

    // reference flags
    // set wins over clear when the levels are crossed
    task automatic evaluate();
        logic ni;
        logic nf;
        ni = (cap < iset) ? 1'b1 : ((cap > iclr) ? 1'b0 : fi);
        nf = (fset != 8'h00 && cap < fset) ? 1'b1 : ((cap > fclr && ff) ? 1'b0 : ff);
        sts = sts | {ff & ~nf, ~ff & nf, fi & ~ni, ~fi & ni};
        rises = rises + int'(~fi & ni);
        fi = ni;
        ff = nf;
    endtask : evaluate

    task automatic verify();
        repeat (5) @(posedge clk);
        check(pin, fi);
        check(irq, |(sts & msk));
        check(alarms, rises);
        rd_chk(OFS_FLAGS, {30'h0, ff, fi});
        rd_chk(OFS_IRQ_STATUS, {28'h0, sts});
        rd_chk(OFS_CAPACITY, {16'h0, cap});
    endtask : verify

    task automatic set_cap(input logic [CAP_WIDTH-1:0] d);
        access(1'b1, OFS_CAPACITY, {16'h0, d}, 4'hF);
        cap = d;
        evaluate();
        verify();
    endtask : set_cap

    // charge accumulation
    // samples arrive back to back; capacity saturates at both ends
    task automatic burst(input int n, input int bias);
        int d;
        int c;
        for (int k = 0; k < n; k++) begin
            d = ($random(seed) % 20) + bias;
            @(posedge clk);
            chg_vld <= 1'b1;
            chg <= d[15:0];
            c = int'(cap) + d;
            cap = (c < 0) ? 16'h0000 : ((c > 65535) ? 16'hFFFF : c[15:0]);
            evaluate();
        end
        @(posedge clk);
        chg_vld <= 1'b0;
        verify();
    endtask : burst

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(OFS_CAPACITY, {16'h0, RST_CAPACITY});
        rd_chk(OFS_LEVELS, {RST_FINAL_CLEAR, RST_FINAL_SET, RST_INIT_CLEAR, RST_INIT_SET});
        rd_chk(OFS_IRQ_MASK, 32'h0);
        rd_chk(5'h14, 32'h0);
        set_cap(16'h00C8);
        // discharge through both set levels into the floor; mask still closed
        repeat (6) burst(8, -12);
        access(1'b1, OFS_IRQ_MASK, 32'h1, 4'h1);
        msk = 4'h1;
        verify();
        access(1'b1, OFS_IRQ_STATUS, 32'hF, 4'h1);
        sts = 4'h0;
        // flags are read-only, this write must leave them alone
        access(1'b1, OFS_FLAGS, 32'h0, 4'hF);
        verify();
        repeat (8) burst(8, 12);
        access(1'b1, OFS_LEVELS, 32'h0, 4'h4);
        fset = 8'h00;
        set_cap(16'h000A);
        set_cap(16'h00B0);
        set_cap(16'hFFF0);
        burst(4, 30);
        wrap_up();
    end

    // the whole run needs under five hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
endmodule : testbench
